// ==== logic/xfer_ctl_pkg.sv ====
// Constants for the per-channel transfer enable and acknowledge control block
package xfer_ctl_pkg;
   // ----------------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] CTRL_BASE = 8'h00;    // Channel control, one word per channel
   localparam logic [7:0] STAT_OFS = 8'h08;     // Status word
   localparam logic [7:0] CNT_BASE = 8'h10;     // Transfer count, one word per channel
   localparam logic [7:0] CH_STRIDE = 8'h04;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Control word fields
   // ----------------------------------------------------------------
   localparam int CTRL_W = 10;
   localparam int ACK_BIT = 9;                  // source_clear_on_transfer
   localparam int RSV_BIT = 8;                  // Reserved, plain storage
   localparam int ME_BIT = 7;                   // master_transfer_enable
   localparam int TE_BIT = 6;                   // channel_transfer_enable
   localparam int BURST_BIT = 5;                // 1 burst mode, 0 block mode
   localparam int SRC_LSB = 0;
   localparam int SRC_W = 3;
   localparam logic [9:0] CTRL_RST = 10'h000;
   localparam logic [9:0] CTRL_WMASK = 10'h367; // Bits stored directly (not the master enable, nor bits 4:3)

   // ----------------------------------------------------------------
   // Request source codes
   // ----------------------------------------------------------------
   localparam logic [2:0] SRC_CONV = 3'h0;
   localparam logic [2:0] SRC_TXEND = 3'h1;
   localparam logic [2:0] SRC_RXEND = 3'h2;
   localparam logic [2:0] SRC_TMR0 = 3'h3;
   localparam logic [2:0] SRC_TMR1 = 3'h4;
   localparam logic [2:0] SRC_TMR2 = 3'h5;
   localparam logic [2:0] SRC_EXT = 3'h6;
   localparam int EXT_CH = 1;                   // Only this channel accepts external requests
   localparam int CNT_W = 16;

   // ----------------------------------------------------------------
   // Channel sequencing states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CH_IDLE = 3'b001,
      CH_BURST = 3'b010,
      CH_SUSP = 3'b100
   } ch_state_e;
endpackage

// ==== logic/xfer_ctl.sv ====
// Two-channel transfer enable, burst suspend and source acknowledge control
`timescale 1ns/100ps
module xfer_ctl #(
   parameter int NCH = 2                            // Number of channels
) (
   input wire logic sys_clk,                        // System clock, 100 MHz
   input wire logic reset,                          // Synchronous reset, active high
   input wire logic [xfer_ctl_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid,                  // Write address valid
   output logic s_axi_awready,                      // Write address ready
   input wire logic [31:0] s_axi_wdata,             // Write data
   input wire logic [3:0] s_axi_wstrb,              // Write byte enables
   input wire logic s_axi_wvalid,                   // Write data valid
   output logic s_axi_wready,                       // Write data ready
   output logic [1:0] s_axi_bresp,                  // Write response
   output logic s_axi_bvalid,                       // Write response valid
   input wire logic s_axi_bready,                   // Write response ready
   input wire logic [xfer_ctl_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid,                  // Read address valid
   output logic s_axi_arready,                      // Read address ready
   output logic [31:0] s_axi_rdata,                 // Read data
   output logic [1:0] s_axi_rresp,                  // Read response
   output logic s_axi_rvalid,                       // Read data valid
   input wire logic s_axi_rready,                   // Read data ready
   input wire logic nmi,                            // Non-maskable interrupt, high active
   input wire logic conv_done_req,                  // Converter conversion end request
   input wire logic serial_tx_req,                  // Serial transmit complete request
   input wire logic serial_rx_req,                  // Serial receive complete request
   input wire logic [2:0] timer_req,                // Timer 0..2 compare/capture A requests
   input wire logic ext_req,                        // External request
   output logic [NCH-1:0] xfer_pulse,               // One transfer performed, per channel
   output logic [NCH-1:0] src_clear,                // Clear strobe to the requesting source
   output logic [NCH-1:0] bus_hold                  // Channel holds bus mastership (burst)
);
   import xfer_ctl_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Picks one request line by source code; the external line only where allowed
   function automatic logic src_pick(input logic [2:0] sel, input logic [6:0] reqs,
                                     input logic ext_ok);
      logic hit;
      hit = 1'b0;
      case (sel)
         SRC_CONV: hit = reqs[0];
         SRC_TXEND: hit = reqs[1];
         SRC_RXEND: hit = reqs[2];
         SRC_TMR0: hit = reqs[3];
         SRC_TMR1: hit = reqs[4];
         SRC_TMR2: hit = reqs[5];
         SRC_EXT: hit = reqs[6] & ext_ok;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Word-aligned address match
   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      return (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
   endfunction

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   logic aw_hold_r;
   logic w_hold_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   wire logic wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
   wire logic [NCH-1:0] wr_hit;
   wire logic [NCH-1:0] wr_cnt_hit;
   wire logic [NCH-1:0] rd_hit;

   assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
   assign s_axi_wready = ~w_hold_r & ~bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // Address and data may come in either order; each is held until both are in
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_hold_r <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   // Write decode; the status word is read-only so writes there are refused
   wire logic wr_mapped = (|wr_hit) | (|wr_cnt_hit);

   // Response is raised on the same edge as the register update
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   wire logic rd_go = s_axi_arvalid & ~rvalid_r;
   wire logic [CTRL_W-1:0] ctrl_all [NCH];
   wire logic [CNT_W-1:0] cnt_all [NCH];
   wire logic [NCH-1:0] busy_all;
   wire logic [NCH-1:0] susp_all;
   logic [31:0] rd_mux;
   logic rd_ok;

   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // Read selection; unmapped words return zero with an error response
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_ok = 1'b0;
      if (addr_is(s_axi_araddr, STAT_OFS)) begin
         rd_mux = {24'h00_0000, 4'(susp_all), 4'(busy_all)};
         rd_ok = 1'b1;
      end
      for (int i = 0; i < NCH; i++) begin
         if (addr_is(s_axi_araddr, CTRL_BASE + 8'(i * 4))) begin
            rd_mux = {22'h00_0000, ctrl_all[i]};
            rd_ok = 1'b1;
         end
         if (addr_is(s_axi_araddr, CNT_BASE + 8'(i * 4))) begin
            rd_mux = {16'h0000, cnt_all[i]};
            rd_ok = 1'b1;
         end
      end
   end

   // Data is answered one cycle after the address is taken
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   wire logic [6:0] req_vec = {ext_req, timer_req, serial_rx_req, serial_tx_req, conv_done_req};

   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         localparam logic [7:0] CTRL_OFS = CTRL_BASE + 8'(c * 4);
         localparam logic [7:0] CNT_OFS = CNT_BASE + 8'(c * 4);
         logic [CTRL_W-1:0] ctrl_r;
         logic [CTRL_W-1:0] ctrl_nxt;
         logic me_r;
         logic me_nxt;
         logic armed_r;
         logic [CNT_W-1:0] cnt_r;
         ch_state_e st_r;
         ch_state_e st_nxt;
         logic xfer_r;
         logic clr_r;
         logic xfer_go;

         assign wr_hit[c] = wr_go & addr_is(awaddr_r, CTRL_OFS);
         assign wr_cnt_hit[c] = wr_go & addr_is(awaddr_r, CNT_OFS);
         assign rd_hit[c] = rd_go & addr_is(s_axi_araddr, CTRL_OFS);

         // Decoded fields and events of this channel
         wire logic burst = ctrl_r[BURST_BIT];
         wire logic enabled = me_r & ctrl_r[TE_BIT];
         wire logic req = src_pick(ctrl_r[SRC_LSB +: SRC_W], req_vec,
                                   (c == EXT_CH));
         wire logic cnt_left = (cnt_r != '0);
         wire logic nmi_hit = nmi & burst;
         wire logic me_wr = wr_hit[c] & wstrb_r[0];
         wire logic start = (st_r == CH_IDLE) & enabled & req & cnt_left & ~nmi_hit;

         // Byte-lane merge of the stored control bits; reserved bit 8 simply stores
         always_comb begin
            ctrl_nxt = ctrl_r;
            if (wr_hit[c] & wstrb_r[0]) begin
               ctrl_nxt[7:0] = wdata_r[7:0];
            end
            if (wr_hit[c] & wstrb_r[1]) begin
               ctrl_nxt[9:8] = wdata_r[9:8];
            end
            ctrl_nxt = (ctrl_nxt & CTRL_WMASK) | {2'b00, me_nxt, 7'h00};
         end

         // Master enable: interrupt clear beats any write; a 1 only lands when armed
         always_comb begin
            me_nxt = me_r;
            if (nmi_hit) begin
               me_nxt = 1'b0;
            end else if (me_wr) begin
               me_nxt = wdata_r[ME_BIT] ? (me_r | armed_r) : 1'b0;
            end
         end

         // Sequencing of a burst, its suspension and its resumption
         always_comb begin
            st_nxt = st_r;
            xfer_go = 1'b0;
            case (st_r)
               CH_IDLE: begin
                  if (start) begin
                     xfer_go = 1'b1;
                     if (burst && cnt_r != CNT_W'(1)) begin
                        st_nxt = CH_BURST;
                     end
                  end
               end
               CH_BURST: begin
                  if (nmi_hit) begin
                     st_nxt = CH_SUSP;
                  end else if (!enabled || !cnt_left) begin
                     st_nxt = CH_IDLE;
                  end else begin
                     xfer_go = 1'b1;
                     if (cnt_r == CNT_W'(1)) begin
                        st_nxt = CH_IDLE;
                     end
                  end
               end
               CH_SUSP: begin
                  if (enabled && !nmi_hit) begin
                     st_nxt = CH_BURST;
                  end else if (!ctrl_r[TE_BIT]) begin
                     st_nxt = CH_IDLE;
                  end
               end
               default: st_nxt = CH_IDLE;
            endcase
         end

         // Control and arming; the arm set wins over a same-cycle clear
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               ctrl_r <= CTRL_RST;
               me_r <= 1'b0;
               armed_r <= 1'b0;
            end else begin
               ctrl_r <= ctrl_nxt;
               me_r <= me_nxt;
               if (rd_hit[c] && !me_r) begin
                  armed_r <= 1'b1;
               end else if (me_wr) begin
                  armed_r <= 1'b0;
               end
            end
         end

         // Software load of the count takes priority over a decrement
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               cnt_r <= '0;
            end else if (wr_cnt_hit[c]) begin
               cnt_r <= wdata_r[CNT_W-1:0];
            end else if (xfer_go) begin
               cnt_r <= cnt_r - CNT_W'(1);
            end
         end

         // State and strobes; only the request that started a run is cleared
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               st_r <= CH_IDLE;
               xfer_r <= 1'b0;
               clr_r <= 1'b0;
            end else begin
               st_r <= st_nxt;
               xfer_r <= xfer_go;
               clr_r <= start & ctrl_r[ACK_BIT];
            end
         end

         assign ctrl_all[c] = {ctrl_r[9:8], me_r, ctrl_r[6:0]};
         assign cnt_all[c] = cnt_r;
         assign busy_all[c] = (st_r == CH_BURST);
         assign susp_all[c] = (st_r == CH_SUSP);
         assign xfer_pulse[c] = xfer_r;
         assign src_clear[c] = clr_r;
         // Suspended burst gives the bus back to the processor
         assign bus_hold[c] = (st_r == CH_BURST);
      end
   endgenerate
endmodule

// ==== sim/xfer_ctl_checker.sv ====
// Concurrent checks on the ports of the transfer enable control block
`timescale 1ns/100ps
module xfer_ctl_checker
   import xfer_ctl_pkg::*;
#(
   parameter int NCH = 2                       // Channel count
) (
   input wire logic sys_clk,                   // Clock
   input wire logic reset,                     // Reset
   input wire logic s_axi_awvalid,             // AW valid
   input wire logic s_axi_awready,             // AW ready
   input wire logic s_axi_wvalid,              // W valid
   input wire logic s_axi_wready,              // W ready
   input wire logic [1:0] s_axi_bresp,         // B response
   input wire logic s_axi_bvalid,              // B valid
   input wire logic s_axi_bready,              // B ready
   input wire logic s_axi_arvalid,             // AR valid
   input wire logic s_axi_arready,             // AR ready
   input wire logic [31:0] s_axi_rdata,        // Read data
   input wire logic s_axi_rvalid,              // R valid
   input wire logic s_axi_rready,              // R ready
   input wire logic nmi,                       // Interrupt
   input wire logic [NCH-1:0] xfer_pulse,      // Transfers
   input wire logic [NCH-1:0] src_clear,       // Source clears
   input wire logic [NCH-1:0] bus_hold         // Bus held
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Reset has to silence the transfer, bus hold and response strobes, so it is checked without the disable
   AST_RESET_QUIET: assert property (disable iff (1'h0) reset |=>
      (xfer_pulse == '0 && bus_hold == '0 && !s_axi_bvalid && !s_axi_rvalid))
      else $error("outputs active after reset");
   // Per channel: interrupt releases the bus, clear strobe only with a transfer
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      AST_NMI_RELEASE: assert property (bus_hold[c] && nmi |=> !bus_hold[c])
         else $error("bus still held after interrupt");
      AST_CLEAR_WITH_XFER: assert property (src_clear[c] |-> xfer_pulse[c])
         else $error("source clear without transfer");
   end
   AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   AST_AW_REFUSED: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken during response");
   COV_NMI_BURST: cover property (bus_hold[0] && nmi);
   COV_CLEAR: cover property (src_clear[1]);
   COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind xfer_ctl xfer_ctl_checker #(.NCH(NCH)) u_chk (.sys_clk(sys_clk), .reset(reset),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .nmi(nmi), .xfer_pulse(xfer_pulse), .src_clear(src_clear), .bus_hold(bus_hold));

// ==== sim/req_src_model.sv ====
// Model of the peripheral request sources feeding the transfer block
`timescale 1ns/100ps
module req_src_model #(
   parameter int W = 7                  // Number of sources
) (
   input wire logic sys_clk,            // Clock
   input wire logic reset,              // Reset
   input wire logic [W-1:0] raise,      // Event sets a request
   input wire logic [W-1:0] drop,       // Software clears a request
   input wire logic [W-1:0] ack_clear,  // Cleared by a transfer
   output logic [W-1:0] req             // Request levels
);
   logic [W-1:0] req_r;
   // A flag keeps asking until served or cleared, so a lost clear shows up
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         req_r <= '0;
      end else begin
         req_r <= (req_r & ~(drop | ack_clear)) | raise;
      end
   end
   assign req = req_r;
endmodule

// ==== sim/xfer_ctl_tb_top.sv ====
// Self-checking testbench for the transfer enable control block
`timescale 1ns/100ps
module xfer_ctl_tb_top;
   import xfer_ctl_pkg::*;
   logic sys_clk = 1'h0, reset = 1'h1, nmi = 1'h0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'h9570142c;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, xfer_pulse, src_clear, bus_hold;
   logic [6:0] req, raise = '0, drop = '0, clr;
   logic [2:0] sel [2] = '{3'h7, 3'h7};
   int bad_count = 0, n_compared = 0, npulse [2] = '{0, 0};
   always #5 sys_clk = ~sys_clk;
   // Route each channel's clear strobe to the source it selected
   always_comb begin
      clr = '0;
      for (int c = 0; c < 2; c++) if (src_clear[c] === 1'h1) clr[sel[c]] = 1'h1;
   end
   always @(posedge sys_clk) for (int c = 0; c < 2; c++) if (xfer_pulse[c] === 1'h1) npulse[c]++;
   xfer_ctl #(.NCH(2)) uut (.sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .nmi(nmi), .conv_done_req(req[0]), .serial_tx_req(req[1]),
      .serial_rx_req(req[2]), .timer_req(req[5:3]), .ext_req(req[6]),
      .xfer_pulse(xfer_pulse), .src_clear(src_clear), .bus_hold(bus_hold));
   req_src_model #(.W(7)) u_src (.sys_clk(sys_clk), .reset(reset), .raise(raise),
      .drop(drop), .ack_clear(clr), .req(req));
   // Control word as written and as read back; reserved bit 8 always 0
   function automatic logic [31:0] ctrl_word(input logic ack, me, te, bst, input logic [2:0] s);
      return {22'h0, ack, 1'h0, me, te, bst, 2'h0, s};
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [31:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic test_done;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Bus master tasks: hold each channel until its ready is sampled
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'h1 && s_axi_awvalid) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1 && s_axi_wvalid) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1) break;
      end
      s_axi_bready <= 1'h0;
      chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'h1, er}, "write response");
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (s_axi_arready === 1'h1 && s_axi_arvalid) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1) break;
      end
      s_axi_rready <= 1'h0;
      d = s_axi_rdata;
      chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'h1, er}, "read response");
   endtask
   // Enable needs a read of 0 before the write of 1
   task automatic en_ch(input int c, input logic [31:0] w);
      logic [31:0] d;
      axi_rd(CTRL_BASE + 8'(4 * c), d, RESP_OKAY);
      axi_wr(CTRL_BASE + 8'(4 * c), w, RESP_OKAY);
   endtask
   task automatic pulse_in(input logic [6:0] r, input logic n);
      @(posedge sys_clk);
      raise <= r;
      nmi <= n;
      @(posedge sys_clk);
      raise <= '0;
      nmi <= 1'h0;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      $display("unexpected at %0t: run hung", $time);
      test_done();
   end
   initial begin
      logic [31:0] d;
      int c, s, p, n, i;
      logic ack, ok;
      repeat (12) @(posedge sys_clk);
      reset <= 1'h0;
      axi_rd(CTRL_BASE, d, RESP_OKAY);
      chk(d, 32'h0, "ctrl0 reset");
      axi_rd(CTRL_BASE + CH_STRIDE, d, RESP_OKAY);
      chk(d, 32'h0, "ctrl1 reset");
      axi_rd(8'h20, d, RESP_SLVERR);
      chk(d, 32'h0, "unmapped read");
      axi_wr(8'h24, 32'hffffffff, RESP_SLVERR);
      axi_wr(STAT_OFS, 32'h0, RESP_SLVERR);
      $display("test reset_and_map done");
      // A write of 1 without the read of 0 must not enable
      axi_wr(CTRL_BASE, ctrl_word(1'h0, 1'h0, 1'h1, 1'h0, 3'h7), RESP_OKAY);
      axi_wr(CTRL_BASE, ctrl_word(1'h0, 1'h1, 1'h1, 1'h0, 3'h7), RESP_OKAY);
      axi_rd(CTRL_BASE, d, RESP_OKAY);
      chk(d, ctrl_word(1'h0, 1'h0, 1'h1, 1'h0, 3'h7), "enable set unread");
      axi_wr(CTRL_BASE, ctrl_word(1'h0, 1'h1, 1'h1, 1'h0, 3'h7), RESP_OKAY);
      axi_rd(CTRL_BASE, d, RESP_OKAY);
      chk(d, ctrl_word(1'h0, 1'h1, 1'h1, 1'h0, 3'h7), "enable set");
      axi_wr(CTRL_BASE, ctrl_word(1'h0, 1'h0, 1'h1, 1'h0, 3'h7), RESP_OKAY);
      axi_rd(CTRL_BASE, d, RESP_OKAY);
      chk(d, ctrl_word(1'h0, 1'h0, 1'h1, 1'h0, 3'h7), "enable cleared");
      $display("test enable_arm done");
      // Every source in block mode; external on the wrong channel; channel enable off
      for (int k = 0; k < 9; k++) begin
         c = (k == 6) ? 1 : 0;
         s = (k == 8) ? 0 : ((k > 6) ? 6 : k);
         ok = (k < 7);
         seed = xs(seed);
         ack = seed[0];
         sel[c] = 3'(s);
         axi_wr(CNT_BASE + 8'(4 * c), 32'h1, RESP_OKAY);
         en_ch(c, ctrl_word(ack, 1'h1, k != 8, 1'h0, 3'(s)));
         p = npulse[c];
         pulse_in(7'h1 << s, 1'h0);
         repeat (10) @(posedge sys_clk);
         chk(npulse[c] - p, {31'h0, ok}, "transfers per source");
         chk({31'h0, req[s]}, {31'h0, !(ok && ack)}, "source cleared");
         axi_wr(CTRL_BASE + 8'(4 * c), 32'h0, RESP_OKAY);
         @(posedge sys_clk);
         drop <= '1;
         @(posedge sys_clk);
         drop <= '0;
      end
      $display("test sources done");
      // Burst stopped by the interrupt, then resumed from where it stood
      seed = xs(seed);
      n = 8 + seed[3:0];
      sel[0] = SRC_CONV;
      axi_wr(CNT_BASE, 32'(n), RESP_OKAY);
      en_ch(0, ctrl_word(1'h0, 1'h1, 1'h1, 1'h1, SRC_CONV));
      p = npulse[0];
      pulse_in(7'h1, 1'h0);
      for (i = 0; i < 20 && bus_hold[0] !== 1'h1; i++) @(posedge sys_clk);
      pulse_in(7'h0, 1'h1);
      // The state flop moves on the edge that takes the interrupt; look one edge later
      @(posedge sys_clk);
      chk({31'h0, bus_hold[0]}, 32'h0, "bus released");
      axi_rd(STAT_OFS, d, RESP_OKAY);
      chk(d, 32'h10, "status suspended");
      axi_rd(CTRL_BASE, d, RESP_OKAY);
      chk(d, ctrl_word(1'h0, 1'h0, 1'h1, 1'h1, SRC_CONV), "enable after interrupt");
      axi_rd(CNT_BASE, d, RESP_OKAY);
      chk({31'h0, d != 32'h0}, 32'h1, "stopped mid run");
      chk(d + 32'(npulse[0] - p), 32'(n), "count kept");
      axi_wr(CTRL_BASE, ctrl_word(1'h0, 1'h1, 1'h1, 1'h1, SRC_CONV), RESP_OKAY);
      for (i = 0; i < 60 && npulse[0] - p < n; i++) @(posedge sys_clk);
      repeat (3) @(posedge sys_clk);
      chk(32'(npulse[0] - p), 32'(n), "burst resumed");
      axi_wr(CTRL_BASE, 32'h0, RESP_OKAY);
      $display("test burst_interrupt done");
      // Block mode ignores the interrupt
      sel[1] = SRC_TMR0;
      axi_wr(CNT_BASE + CH_STRIDE, 32'h1, RESP_OKAY);
      en_ch(1, ctrl_word(1'h1, 1'h1, 1'h1, 1'h0, SRC_TMR0));
      pulse_in(7'h0, 1'h1);
      axi_rd(CTRL_BASE + CH_STRIDE, d, RESP_OKAY);
      chk(d, ctrl_word(1'h1, 1'h1, 1'h1, 1'h0, SRC_TMR0), "block enable kept");
      p = npulse[1];
      pulse_in(7'h8, 1'h0);
      repeat (10) @(posedge sys_clk);
      chk(32'(npulse[1] - p), 32'h1, "block transfer");
      $display("test block_interrupt done");
      test_done();
   end
endmodule
